// ### rtl/nic_defines.svh
// Constants of the nested interrupt controller: offsets, fields, resets, codes
`ifndef NIC_DEFINES_SVH
`define NIC_DEFINES_SVH

// ****************************************
// Register map (byte addresses, word aligned)
// ****************************************
`define ADDR_CC 6'h00
`define ADDR_PRIO0 6'h04
`define ADDR_PRIO1 6'h08
`define ADDR_PRIO2 6'h0c
`define ADDR_PRIO3 6'h10
`define ADDR_STATUS 6'h14
`define ADDR_ENABLE 6'h18
`define ADDR_HALTCAP 6'h1c
`define ADDR_SP 6'h20

// ****************************************
// Fields and codes
// ****************************************
`define CC_BIT_HI 5
`define CC_BIT_LO 3
`define CC_RESET 8'hea
`define PRIO_RESET 8'hff
`define PRIO3_RO_MASK 8'hf0
`define LVL0 2'b10
`define LVL1 2'b01
`define LVL2 2'b00
`define LVL3 2'b11
`define NUM_VEC 14
`define VEC_BASE 16'hffe0
`define VEC_TOP 16'hffff
`define VEC_RESET 16'hfffe
`define VEC_TRAP 16'hfffc
`define VEC_SLOT0 16'hfffa
`define HALTCAP_RESET 14'h20be
`define SP_RESET 8'hff

`endif

// ### rtl/nic_pkg.sv
// Types shared by the nested interrupt controller
package nic_pkg;
    typedef struct packed {
        logic [5:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avmm_req_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avmm_rsp_type;

    // One-cycle pulses from the core's execution unit
    typedef struct packed {
        logic boundary;
        logic trap;
        logic return_from_interrupt;
        logic interrupt_enable_instr;
        logic interrupt_disable_instr;
        logic halt;
        logic wait_for_interrupt_instr;
        logic pop_cc;
        logic [7:0] pop_value;
    } core_evt_type;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_PUSH,
        ST_LOAD,
        ST_POP,
        ST_WAIT,
        ST_HALT
    } state_type;
endpackage

// ### rtl/nested_interrupt_controller.sv
// Nested interrupt controller: arbitration, entry, return and low-power wake
//
// Functional notes
// - Codes: level0 10, level1 01, level2 00, level3 11
// - Entry stacks context, loads priority, fetches vector
// - Return pops context, restoring previous priority field
// - Highest software priority, then highest hardware priority
// - Unique hardware order gives exactly one winner
// - Unserviced requests stay latched as pending
// - Reset, trap ignore field; force level three
// - Non-maskable sources wake from halt
// - Trap instruction raises trap through same flow
// - Maskable served only if enabled and strictly higher
// - Sixteen vectors FFE0h to FFFFh, four levels
// - Edge external requests latched, cleared on entry; wake
// - Shared external line pins combined by OR
// - Peripheral request needs flag and enable set
// - Flag-clearing sequence drops unserviced pending request
// - Any interrupt wakes wait; halt exit needs capability
// - Non-capable top request served right after first
// - Stack overflow is not detected or flagged
// - Condition code resets to 111x 1010
// - Enable, disable, halt, wait, return, pop change field
// - Vector priorities reset ones; level0 writes ignored
// - Enable instruction loads 10, disable loads 11
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "nic_defines.svh"

module nested_interrupt_controller (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire nic_pkg::avmm_req_type i_avmm,
    output nic_pkg::avmm_rsp_type o_avmm,
    input wire nic_pkg::core_evt_type i_core,
    input wire logic [3:0] i_ext_pins [4],
    input wire logic [3:0] i_ext_sel [4],
    input wire logic [`NUM_VEC-1:0] i_periph_flag,
    input wire logic [`NUM_VEC-1:0] i_periph_en,
    input wire logic [`NUM_VEC-1:0] i_periph_clear,
    output logic o_irq_take,
    output logic [15:0] o_vector,
    output logic [7:0] o_cc,
    output logic o_stack_we,
    output logic [7:0] o_stack_addr,
    output logic [7:0] o_stack_wdata,
    input wire logic [7:0] i_stack_rdata,
    input wire logic [31:0] i_context,
    output logic [31:0] o_context,
    output logic o_restore,
    output logic o_core_stall
);
    // External lines map onto vectors 2..5
    localparam int EXT_BASE = 2;

    logic [7:0] cc_reg;
    logic [7:0] prio_reg [4];
    logic [`NUM_VEC-1:0] pend_reg;
    logic [`NUM_VEC-1:0] halt_cap_reg;
    logic [7:0] sp_reg;
    logic [31:0] ctx_reg;
    logic [2:0] cnt_reg;
    logic first_halt_reg;
    logic [3:0] sel_vec_reg;
    logic sel_nmi_reg;
    nic_pkg::state_type state_reg;
    logic [3:0] ext_s1_reg [4];
    logic [3:0] ext_s2_reg [4];
    logic [3:0] ext_prev_reg;
    logic [3:0] ext_line;
    logic [3:0] ext_rise;
    logic [`NUM_VEC-1:0] req;
    logic [`NUM_VEC-1:0] eligible;
    logic win_any;
    logic [3:0] win_idx;
    logic [1:0] cur_field;

    // ****************************************
    // Helper functions
    // ****************************************
    // Code to a rank 0..3
    function automatic logic [1:0] rank(input logic [1:0] code);
        case (code)
            `LVL0: rank = 2'd0;
            `LVL1: rank = 2'd1;
            `LVL2: rank = 2'd2;
            default: rank = 2'd3;
        endcase
    endfunction

    function automatic logic [1:0] vec_prio(input logic [3:0] idx, input logic [7:0] r [4]);
        logic [7:0] b;
        b = r[idx[3:2]];
        vec_prio = b[{idx[1:0], 1'b0} +: 2];
    endfunction

    // Level 0 code in a pair keeps the old pair
    function automatic logic [7:0] prio_merge(input logic [7:0] old_v, input logic [7:0] new_v);
        logic [7:0] m;
        m = new_v;
        for (int k = 0; k < 4; k++) begin
            if (new_v[2*k +: 2] == `LVL0) begin
                m[2*k +: 2] = old_v[2*k +: 2];
            end
        end
        prio_merge = m;
    endfunction

    assign cur_field = {cc_reg[`CC_BIT_HI], cc_reg[`CC_BIT_LO]};

    // ****************************************
    // Request sources
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int g = 0; g < 4; g++) begin
                ext_s1_reg[g] <= 4'h0;
                ext_s2_reg[g] <= 4'h0;
            end
        end else begin
            for (int g = 0; g < 4; g++) begin
                ext_s1_reg[g] <= i_ext_pins[g];
                ext_s2_reg[g] <= ext_s1_reg[g];
            end
        end
    end

    always_comb begin
        for (int g = 0; g < 4; g++) begin
            ext_line[g] = |(ext_s2_reg[g] & i_ext_sel[g]);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_prev_reg <= 4'h0;
        end else begin
            ext_prev_reg <= ext_line;
        end
    end

    assign ext_rise = ext_line & ~ext_prev_reg;

    always_comb begin
        req = '0;
        for (int v = 1; v < `NUM_VEC; v++) begin
            req[v] = i_periph_flag[v] & i_periph_en[v];
        end
        for (int g = 0; g < 4; g++) begin
            req[EXT_BASE+g] = ext_rise[g];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_reg <= '0;
        end else begin
            for (int v = 0; v < `NUM_VEC; v++) begin
                if (req[v]) begin
                    pend_reg[v] <= 1'b1;
                end else if (i_periph_clear[v] && !(v >= EXT_BASE && v < EXT_BASE + 4)) begin
                    pend_reg[v] <= 1'b0;
                end else if (state_reg == nic_pkg::ST_LOAD && !sel_nmi_reg && sel_vec_reg == v[3:0]) begin
                    pend_reg[v] <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Arbitration
    // ****************************************
    always_comb begin
        for (int v = 0; v < `NUM_VEC; v++) begin
            eligible[v] = pend_reg[v] && i_periph_en[v] &&
                          (rank(vec_prio(v[3:0], prio_reg)) > rank(cur_field));
            if (v >= EXT_BASE && v < EXT_BASE + 4) begin
                eligible[v] = pend_reg[v] && (rank(vec_prio(v[3:0], prio_reg)) > rank(cur_field));
            end
            // first after halt must be capable
            if (first_halt_reg && !halt_cap_reg[v]) begin
                eligible[v] = 1'b0;
            end
        end
        win_any = 1'b0;
        win_idx = 4'h0;
        for (int v = `NUM_VEC - 1; v >= 0; v--) begin
            if (eligible[v] && (!win_any ||
                rank(vec_prio(v[3:0], prio_reg)) >= rank(vec_prio(win_idx, prio_reg)))) begin
                win_any = 1'b1;
                win_idx = v[3:0];
            end
        end
    end

    // ****************************************
    // Service sequencer
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= nic_pkg::ST_RUN;
            cnt_reg <= 3'd0;
            sel_vec_reg <= 4'h0;
            sel_nmi_reg <= 1'b0;
            first_halt_reg <= 1'b0;
            ctx_reg <= '0;
        end else begin
            case (state_reg)
                nic_pkg::ST_RUN: begin
                    if (i_core.boundary) begin
                        cnt_reg <= 3'd0;
                        if (i_core.trap) begin
                            sel_nmi_reg <= 1'b1;
                            ctx_reg <= i_context;
                            state_reg <= nic_pkg::ST_PUSH;
                        end else if (i_core.return_from_interrupt) begin
                            state_reg <= nic_pkg::ST_POP;
                        end else if (win_any) begin
                            sel_nmi_reg <= 1'b0;
                            sel_vec_reg <= win_idx;
                            ctx_reg <= i_context;
                            state_reg <= nic_pkg::ST_PUSH;
                        end else if (i_core.halt) begin
                            state_reg <= nic_pkg::ST_HALT;
                        end else if (i_core.wait_for_interrupt_instr) begin
                            state_reg <= nic_pkg::ST_WAIT;
                        end
                    end
                end
                nic_pkg::ST_PUSH: begin
                    cnt_reg <= cnt_reg + 3'd1;
                    if (cnt_reg == 3'd4) begin
                        state_reg <= nic_pkg::ST_LOAD;
                    end
                end
                nic_pkg::ST_LOAD: begin
                    first_halt_reg <= 1'b0;
                    state_reg <= nic_pkg::ST_RUN;
                end
                nic_pkg::ST_POP: begin
                    cnt_reg <= cnt_reg + 3'd1;
                    ctx_reg <= {ctx_reg[23:0], i_stack_rdata};
                    if (cnt_reg == 3'd4) begin
                        state_reg <= nic_pkg::ST_RUN;
                    end
                end
                nic_pkg::ST_WAIT: begin
                    if (|pend_reg) begin
                        state_reg <= nic_pkg::ST_RUN;
                    end
                end
                nic_pkg::ST_HALT: begin
                    if (|(pend_reg & halt_cap_reg)) begin
                        first_halt_reg <= 1'b1;
                        state_reg <= nic_pkg::ST_RUN;
                    end
                end
                default: state_reg <= nic_pkg::ST_RUN;
            endcase
        end
    end

    // ****************************************
    // Condition code and stack pointer
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cc_reg <= `CC_RESET;
        end else if (state_reg == nic_pkg::ST_LOAD) begin
            if (sel_nmi_reg) begin
                cc_reg[`CC_BIT_HI] <= 1'b1;
                cc_reg[`CC_BIT_LO] <= 1'b1;
            end else begin
                {cc_reg[`CC_BIT_HI], cc_reg[`CC_BIT_LO]} <= vec_prio(sel_vec_reg, prio_reg);
            end
        end else if (state_reg == nic_pkg::ST_POP && cnt_reg == 3'd0) begin
            cc_reg <= i_stack_rdata;
        end else if (avmm_wr(`ADDR_CC)) begin
            cc_reg <= i_avmm.writedata[7:0];
        end else if (state_reg == nic_pkg::ST_RUN && i_core.boundary && !i_core.trap) begin
            if (i_core.pop_cc) begin
                cc_reg <= i_core.pop_value;
            end else if (i_core.interrupt_enable_instr || i_core.halt || i_core.wait_for_interrupt_instr) begin
                {cc_reg[`CC_BIT_HI], cc_reg[`CC_BIT_LO]} <= `LVL0;
            end else if (i_core.interrupt_disable_instr) begin
                {cc_reg[`CC_BIT_HI], cc_reg[`CC_BIT_LO]} <= `LVL3;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sp_reg <= `SP_RESET;
        end else if (state_reg == nic_pkg::ST_PUSH) begin
            sp_reg <= sp_reg - 8'h01;
        end else if (state_reg == nic_pkg::ST_POP) begin
            sp_reg <= sp_reg + 8'h01;
        end else if (avmm_wr(`ADDR_SP)) begin
            sp_reg <= i_avmm.writedata[7:0];
        end
    end

    // ****************************************
    // Register bus
    // ****************************************
    function automatic logic avmm_wr(input logic [5:0] a);
        avmm_wr = i_avmm.write && i_avmm.address == a;
    endfunction

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int r = 0; r < 4; r++) begin
                prio_reg[r] <= `PRIO_RESET;
            end
        end else begin
            for (int r = 0; r < 4; r++) begin
                if (avmm_wr(6'(`ADDR_PRIO0 + 4 * r))) begin
                    prio_reg[r] <= prio_merge(prio_reg[r], i_avmm.writedata[7:0]) |
                                   (r == 3 ? `PRIO3_RO_MASK : 8'h00);
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            halt_cap_reg <= `HALTCAP_RESET;
        end else if (avmm_wr(`ADDR_HALTCAP)) begin
            halt_cap_reg <= i_avmm.writedata[`NUM_VEC-1:0];
        end
    end

    always_comb begin
        o_avmm.waitrequest = 1'b0;
        case (i_avmm.address)
            `ADDR_CC: o_avmm.readdata = {24'h0, cc_reg};
            `ADDR_PRIO0: o_avmm.readdata = {24'h0, prio_reg[0]};
            `ADDR_PRIO1: o_avmm.readdata = {24'h0, prio_reg[1]};
            `ADDR_PRIO2: o_avmm.readdata = {24'h0, prio_reg[2]};
            `ADDR_PRIO3: o_avmm.readdata = {24'h0, prio_reg[3]};
            `ADDR_STATUS: o_avmm.readdata = {18'h0, pend_reg};
            `ADDR_ENABLE: o_avmm.readdata = {18'h0, i_periph_en};
            `ADDR_HALTCAP: o_avmm.readdata = {18'h0, halt_cap_reg};
            `ADDR_SP: o_avmm.readdata = {24'h0, sp_reg};
            default: o_avmm.readdata = 32'h0;
        endcase
    end

    // ****************************************
    // Core side outputs
    // ****************************************
    // vectors from FFFAh down
    assign o_vector = sel_nmi_reg ? `VEC_TRAP : (`VEC_SLOT0 - {11'h0, sel_vec_reg, 1'b0});
    assign o_irq_take = (state_reg == nic_pkg::ST_LOAD);
    assign o_cc = cc_reg;
    assign o_stack_we = (state_reg == nic_pkg::ST_PUSH);
    assign o_stack_addr = (state_reg == nic_pkg::ST_POP) ? sp_reg + 8'h01 : sp_reg;
    // Pushes PC low, PC high, X, A, then CC
    always_comb begin
        case (cnt_reg)
            3'd0: o_stack_wdata = ctx_reg[7:0];
            3'd1: o_stack_wdata = ctx_reg[15:8];
            3'd2: o_stack_wdata = ctx_reg[23:16];
            3'd3: o_stack_wdata = ctx_reg[31:24];
            default: o_stack_wdata = cc_reg;
        endcase
    end
    assign o_context = ctx_reg;
    assign o_restore = (state_reg == nic_pkg::ST_POP && cnt_reg == 3'd4);
    assign o_core_stall = (state_reg != nic_pkg::ST_RUN);
endmodule

// ### verif/stack_model.sv
// Stack memory of the core side, written by pushes and read back by pops
`timescale 1ns/1ps

module stack_model (
    input wire logic i_mclk,
    input wire logic i_we,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [256];

    always @(posedge i_mclk) begin
        if (i_we === 1'b1) begin
            mem[i_addr] <= i_wdata;
        end
    end

    // Unwritten bytes read as unknown, so a wrong pop address shows up
    assign o_rdata = mem[i_addr];
endmodule

// ### verif/nested_interrupt_controller_asserts.sv
// Concurrent checks on the ports of the nested interrupt controller
`timescale 1ns/1ps
`include "nic_defines.svh"

module nested_interrupt_controller_asserts (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire nic_pkg::avmm_req_type i_avmm,
    input wire nic_pkg::core_evt_type i_core,
    input wire logic o_irq_take,
    input wire logic [15:0] o_vector,
    input wire logic [7:0] o_cc,
    input wire logic o_stack_we,
    input wire logic o_restore,
    input wire logic o_core_stall
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    // ****************************************
    // Properties
    // ****************************************
    property p_cc_reset;
        $rose(i_rst_n) |-> o_cc[7:5] == 3'b111 && o_cc[3:0] == 4'ha;
    endproperty
    a_cc_reset: assert property (p_cc_reset) else $error("cc reset value wrong");

    property p_push_seq;
        $rose(o_stack_we) |-> o_stack_we [*5] ##1 (o_irq_take && !o_stack_we);
    endproperty
    a_push_seq: assert property (p_push_seq) else $error("entry push sequence wrong");

    property p_vec_range;
        o_irq_take |-> o_vector >= `VEC_BASE && !o_vector[0] && o_vector != `VEC_RESET;
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector out of range");

    property p_trap_take;
        i_core.boundary && i_core.trap && !o_core_stall |-> ##6 (o_irq_take && o_vector == `VEC_TRAP);
    endproperty
    a_trap_take: assert property (p_trap_take) else $error("trap not taken");

    property p_trap_lvl;
        o_irq_take && o_vector == `VEC_TRAP |=> o_cc[`CC_BIT_HI] && o_cc[`CC_BIT_LO];
    endproperty
    a_trap_lvl: assert property (p_trap_lvl) else $error("trap level wrong");

    property p_mask_l3;
        i_core.boundary && !o_core_stall && !i_core.trap && o_cc[5] && o_cc[3] |=> !o_stack_we;
    endproperty
    a_mask_l3: assert property (p_mask_l3) else $error("entry at level three");

    property p_int_return;
        i_core.boundary && !i_core.trap && i_core.return_from_interrupt && !o_core_stall |-> ##5 o_restore;
    endproperty
    a_int_return: assert property (p_int_return) else $error("return did not restore");

    property p_enable_disable;
        i_core.boundary && !i_core.trap && !i_core.pop_cc && !o_core_stall &&
        (i_core.interrupt_enable_instr || i_core.interrupt_disable_instr) |=>
        o_cc[5] && o_cc[3] == $past(i_core.interrupt_disable_instr);
    endproperty
    a_enable_disable: assert property (p_enable_disable) else $error("enable or disable level wrong");

    property p_lowpow;
        i_core.boundary && !i_core.trap && !i_core.pop_cc && !o_core_stall &&
        (i_core.wait_for_interrupt_instr || i_core.halt) |=> o_cc[5] && !o_cc[3];
    endproperty
    a_lowpow: assert property (p_lowpow) else $error("low power level wrong");

    property p_cc_write;
        i_avmm.write && i_avmm.address == `ADDR_CC |=> o_cc == $past(i_avmm.writedata[7:0]);
    endproperty
    a_cc_write: assert property (p_cc_write) else $error("cc write lost");

    c_take: cover property (o_irq_take);
    c_restore: cover property (o_restore);
    c_trap: cover property (o_irq_take && o_vector == `VEC_TRAP);
endmodule

bind nested_interrupt_controller nested_interrupt_controller_asserts i_nested_interrupt_controller_asserts (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avmm(i_avmm), .i_core(i_core), .o_irq_take(o_irq_take),
    .o_vector(o_vector), .o_cc(o_cc), .o_stack_we(o_stack_we), .o_restore(o_restore), .o_core_stall(o_core_stall));

// ### verif/nested_interrupt_controller_tb.sv
// Self-checking bench of the nested interrupt controller
`timescale 1ns/1ps
`include "nic_defines.svh"

module nested_interrupt_controller_tb;
    localparam logic [6:0] BND = 7'h40, TRP = 7'h20, RET = 7'h10, ENI = 7'h08, DSI = 7'h04, HLT = 7'h02, WTI = 7'h01;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    nic_pkg::avmm_req_type req = '0;
    nic_pkg::avmm_rsp_type rsp;
    nic_pkg::core_evt_type core = '0;
    logic [3:0] pins [4] = '{default: 4'h0};
    logic [3:0] sel [4] = '{default: 4'h0};
    logic [13:0] flag = 14'h0000;
    logic [13:0] en = 14'h0000;
    logic [13:0] clr = 14'h0000;
    logic take, we, rest, stall, take_d, rest_d;
    logic [15:0] vec;
    logic [7:0] cc, saddr, swd, srd;
    logic [1:0] lvl;
    logic [31:0] ctx = 32'h0;
    logic [31:0] octx;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int takes = 0;
    integer seed = 32'hea71;
    logic [17:0] tq [$];
    logic [15:0] rq [$];
    logic [31:0] cq [$];

    always #12.5 i_mclk = ~i_mclk;

    nested_interrupt_controller i_nested_interrupt_controller (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avmm(req), .o_avmm(rsp), .i_core(core), .i_ext_pins(pins),
        .i_ext_sel(sel), .i_periph_flag(flag), .i_periph_en(en), .i_periph_clear(clr), .o_irq_take(take),
        .o_vector(vec), .o_cc(cc), .o_stack_we(we), .o_stack_addr(saddr), .o_stack_wdata(swd),
        .i_stack_rdata(srd), .i_context(ctx), .o_context(octx), .o_restore(rest), .o_core_stall(stall));
    stack_model i_stack_model (.i_mclk(i_mclk), .i_we(we), .i_addr(saddr), .i_wdata(swd), .o_rdata(srd));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        req <= '{address: a, read: !wr, write: wr, writedata: {16'h0000, d}};
        @(posedge i_mclk);
        while (rsp.waitrequest !== 1'b0) begin
            @(posedge i_mclk);
        end
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        rq.push_back(e);
        bus(1'b0, a, 16'h0000);
    endtask

    task automatic ev(input logic [6:0] k);
        @(posedge i_mclk);
        core <= {k | BND, 9'h000};
        @(posedge i_mclk);
        core <= '0;
    endtask

    function automatic logic [15:0] ccv(input logic [1:0] l);
        return {8'h00, 2'b11, l[1], 1'b0, l[0], 3'b010};
    endfunction

    // Boundaries are repeated until the entry shows, covering wake from low power
    task automatic serve(input logic [15:0] v, input logic [1:0] l, input logic [6:0] k);
        int t0;
        logic [31:0] r;
        t0 = takes;
        r = $random(seed);
        ctx <= r;
        cq.push_back(r);
        tq.push_back({l, v});
        for (int i = 0; i < 8 && takes == t0; i++) begin
            ev(k);
            repeat (8) @(posedge i_mclk);
        end
    endtask

    task automatic quiet();
        ev(BND);
        repeat (10) @(posedge i_mclk);
    endtask

    task automatic ret(input logic [1:0] l);
        ev(RET);
        repeat (8) @(posedge i_mclk);
        rd(`ADDR_CC, ccv(l));
    endtask

    task automatic drop(input int v);
        @(posedge i_mclk);
        flag[v] <= 1'b0;
        clr[v] <= 1'b1;
        @(posedge i_mclk);
        clr <= '0;
    endtask

    // ****************************************
    // Monitor
    // ****************************************
    always @(posedge i_mclk) begin
        logic [17:0] e;
        cycles++;
        take_d <= (take === 1'b1);
        rest_d <= (rest === 1'b1);
        if (take_d === 1'b1) begin
            chk(32'({cc[`CC_BIT_HI], cc[`CC_BIT_LO]}), 32'(lvl));
        end
        if (take === 1'b1) begin
            e = (tq.size() > 0) ? tq.pop_front() : 18'h3ffff;
            chk(32'(vec), 32'(e[15:0]));
            lvl <= e[17:16];
            takes++;
        end
        if (rest_d === 1'b1) begin
            chk(octx, (cq.size() > 0) ? cq.pop_back() : 32'hx);
        end
        if (req.read === 1'b1 && rsp.waitrequest === 1'b0) begin
            chk(32'(rsp.readdata[15:0]), 32'(rq.pop_front()));
        end
        if (cycles > 20000) begin
            errors++;
            finish_test();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] r;
        repeat (16) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rd(`ADDR_CC, 16'h00ea);
        for (int i = 0; i < 4; i++) begin
            rd(6'(`ADDR_PRIO0 + 4 * i), 16'h00ff);
        end
        rd(`ADDR_HALTCAP, 16'h20be);
        rd(`ADDR_SP, 16'h00ff);
        rd(6'h3c, 16'h0000);
        wr(`ADDR_PRIO0, 16'h00cf);
        wr(`ADDR_PRIO0, 16'h0064);
        rd(`ADDR_PRIO0, 16'h0044);
        wr(`ADDR_PRIO3, 16'h0000);
        rd(`ADDR_PRIO3, 16'h00f0);
        wr(`ADDR_PRIO0, 16'h0043);
        wr(`ADDR_PRIO1, 16'h003f);
        wr(`ADDR_PRIO2, 16'h00d1);
        wr(`ADDR_ENABLE, 16'h3fff);
        r = $random(seed);
        wr(`ADDR_CC, r[15:0]);
        rd(`ADDR_CC, {8'h00, r[7:0]});
        wr(`ADDR_CC, ccv(2'b11));
        // Tie at level one with a disabled higher source, then nesting
        ev(ENI);
        en <= 14'h0500;
        flag <= 14'h0700;
        serve(16'hffea, 2'b01, BND);
        quiet();
        en <= 14'h0700;
        serve(16'hffe8, 2'b00, BND);
        drop(9);
        ret(2'b01);
        drop(8);
        ret(2'b10);
        serve(16'hffe6, 2'b01, BND);
        drop(10);
        ret(2'b10);
        ev(DSI);
        serve(`VEC_TRAP, 2'b11, BND | TRP);
        ret(2'b11);
        en[11] <= 1'b1;
        flag[11] <= 1'b1;
        quiet();
        rd(`ADDR_STATUS, 16'h0800);
        drop(11);
        rd(`ADDR_STATUS, 16'h0000);
        // External lines with two selected pins each
        ev(ENI);
        for (int g = 0; g < 4; g++) begin
            sel[g] <= 4'b0110;
            pins[g] <= 4'b0100;
            repeat (6) @(posedge i_mclk);
            serve(16'hfff6 - 16'(2 * g), (g < 2) ? 2'(g) : 2'b11, BND);
            rd(`ADDR_STATUS, 16'h0000);
            pins[g] <= 4'h0;
            ret(2'b10);
        end
        // Halt: a source without wake capability waits for a capable one
        ev(HLT);
        flag[8] <= 1'b1;
        repeat (20) @(posedge i_mclk);
        chk(32'(stall), 32'h1);
        pins[0] <= 4'b0100;
        repeat (6) @(posedge i_mclk);
        serve(16'hfff6, 2'b00, BND);
        pins[0] <= 4'h0;
        ret(2'b10);
        serve(16'hffea, 2'b01, BND);
        drop(8);
        ret(2'b10);
        ev(WTI);
        flag[9] <= 1'b1;
        serve(16'hffe8, 2'b00, BND);
        drop(9);
        ret(2'b10);
        repeat (4) @(posedge i_mclk);
        chk(32'(tq.size()), 32'h0);
        finish_test();
    end
endmodule
